// >>> dcsr_pkg.sv
package dcsr_pkg;
  // ----------------------------------------
  // Frame and result layout
  // ----------------------------------------
  localparam int unsigned FRAME_BITS  = 16;   // Serial clocks per frame
  localparam int unsigned RESULT_BITS = 14;   // Converter code width
  localparam int unsigned PAD_BITS    = FRAME_BITS - RESULT_BITS;
  localparam int unsigned BIT_CNT_W   = 5;    // Counts 0..16
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 5'h00;
  localparam logic [RESULT_BITS-1:0] RESULT_RST = 14'h0000;

  // ----------------------------------------
  // Channel codes
  // ----------------------------------------
  localparam logic CHAN0 = 1'b0;
  localparam logic CHAN1 = 1'b1;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    DCSR_IDLE,
    DCSR_SHIFT,
    DCSR_DONE
  } dcsr_state_t;

  // Pin group seen by the device after synchronising
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic chan_sel;
    logic pd_req;
  } dcsr_pins_t;

  // Reset pattern equals the idle pins: chip select high, clock and levels low
  localparam dcsr_pins_t PINS_RST = 4'h8;

  // Serial data output pin as level and enable
  typedef struct packed {
    logic dout;
    logic dout_oe;
  } dcsr_sdo_t;
endpackage : dcsr_pkg

// >>> dcsr_sync.sv
`timescale 1ns/100ps
// ----------------------------------------
// Two-flop synchroniser, one per bit
// ----------------------------------------
module dcsr_sync
  import dcsr_pkg::*;
#(
  parameter int unsigned WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,     // System clock
  input  wire logic             arst_n,  // Async reset
  input  wire logic [WIDTH-1:0] d,       // Asynchronous inputs
  output logic      [WIDTH-1:0] q        // Synchronised outputs
);
  logic [WIDTH-1:0] meta;

  // First stage is read only by the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : dcsr_sync

// >>> dcsr_readout.sv
`timescale 1ns/100ps
// Behaviour
// - One frame is sixteen serial clocks with chip select held low.
// - Each result is a 14-bit code from the converter.
// - Two-way mux routes one channel to the single converter's sample-hold.
// - Channel select low converts channel 0, high converts channel 1.
// - Power-down request sampled at chip select rise; high enters power-down.
// - Chip select active low; frame starts on fall, ends on rise.
// - Each output bit after the leading zero is launched on a serial clock falling edge.
// - Serial data output goes high-impedance when chip select is high.
module dcsr_readout
  import dcsr_pkg::*;
#(
  parameter int unsigned RES_W = RESULT_BITS
) (
  input  wire logic             clk,            // 25 MHz system clock
  input  wire logic             arst_n,         // Async reset, active low
  input  wire logic             cs_n,           // Chip select pin, active low
  input  wire logic             sclk,           // Serial clock pin
  input  wire logic             input_channel_select, // Channel select pin
  input  wire logic             power_down_request,   // Power-down pin
  input  wire logic [RES_W-1:0] chan0_code,     // Converter code, channel 0
  input  wire logic [RES_W-1:0] chan1_code,     // Converter code, channel 1
  output logic                  sdo_out,        // Serial data output level
  output logic                  sdo_oe,         // Serial data output enable
  output logic                  chan_route,     // Mux select to analog front end
  output logic                  sample_hold,    // Sample-and-hold strobe, level
  output logic                  power_down,     // Power-down state
  output logic                  frame_active,   // Frame in progress
  output logic [RES_W-1:0]      last_result     // Last captured code
);
  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  dcsr_pins_t pins_raw;
  dcsr_pins_t pins;
  dcsr_pins_t pins_d;

  assign pins_raw = '{cs_n: cs_n, sclk: sclk, chan_sel: input_channel_select,
                      pd_req: power_down_request};

  // Idle reset pattern, so no false clock edge is seen right after reset
  dcsr_sync #(.WIDTH(4), .RST_VAL(PINS_RST)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (pins_raw),
    .q      (pins)
  );

  // Delayed copy for edge detection on the synchronised pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pins_d <= PINS_RST;
    else         pins_d <= pins;
  end

  logic cs_fall, cs_rise, sclk_rise, sclk_fall;
  assign cs_fall   = pins_d.cs_n & ~pins.cs_n;   // Frame start
  assign cs_rise   = ~pins_d.cs_n & pins.cs_n;   // Frame end
  assign sclk_rise = ~pins_d.sclk & pins.sclk;
  assign sclk_fall = pins_d.sclk & ~pins.sclk;

  // ----------------------------------------
  // Frame state
  // ----------------------------------------
  dcsr_state_t state;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [FRAME_BITS-1:0] shreg;

  // Frame sequencing; any rise of chip select aborts to idle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= DCSR_IDLE;
    end else begin
      case (state)
        DCSR_IDLE:  if (cs_fall) state <= DCSR_SHIFT;
        DCSR_SHIFT: begin
          if (cs_rise) state <= DCSR_IDLE;
          else if (sclk_rise && bit_cnt == BIT_CNT_W'(FRAME_BITS - 1))
            state <= DCSR_DONE;
        end
        DCSR_DONE:  if (cs_rise) state <= DCSR_IDLE;
        default:    state <= DCSR_IDLE;
      endcase
    end
  end

  // Count serial clock rising edges within the frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) bit_cnt <= BIT_CNT_RST;
    else if (cs_fall) bit_cnt <= BIT_CNT_RST;
    else if (state == DCSR_SHIFT && sclk_rise)
      bit_cnt <= bit_cnt + BIT_CNT_W'(1);
  end

  // ----------------------------------------
  // Channel mux and sample-hold
  // ----------------------------------------
  // Follows the pin while idle and during the settle window; frozen at first
  // serial clock rise so the mux is steady through conversion
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) chan_route <= CHAN0;
    else if (state == DCSR_IDLE || (state == DCSR_SHIFT && bit_cnt == BIT_CNT_RST))
      chan_route <= pins.chan_sel ? CHAN1 : CHAN0;
  end

  // Tracking while idle, hold once the frame has started
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) sample_hold <= 1'b0;
    else         sample_hold <= (state != DCSR_IDLE) && !cs_rise;
  end

  // Captured code, latched at the first serial clock rise from the routed channel
  logic [RES_W-1:0] next_code;
  assign next_code = (chan_route == CHAN1) ? chan1_code : chan0_code;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) last_result <= RESULT_RST;
    else if (state == DCSR_SHIFT && sclk_rise && bit_cnt == BIT_CNT_RST)
      last_result <= next_code;
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  // The code enters the register at the first rise; bits leave on falls,
  // so a sample taken at the previous frame's data is never mixed in
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shreg <= '0;
    end else if (cs_fall) begin
      shreg <= '0;
    end else if (state == DCSR_SHIFT && sclk_rise && bit_cnt == BIT_CNT_RST) begin
      shreg <= {1'b0, next_code, {(PAD_BITS - 1){1'b0}}};
    end else if (state != DCSR_IDLE && sclk_fall) begin
      shreg <= {shreg[FRAME_BITS-2:0], 1'b0};
    end
  end

  // Bit 15 is the leading zero; code MSB appears after first falling edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) sdo_out <= 1'b0;
    else if (state == DCSR_IDLE || cs_rise) sdo_out <= 1'b0;
    else if (sclk_fall) sdo_out <= shreg[FRAME_BITS-2];
  end

  // Output driven only while chip select is low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) sdo_oe <= 1'b0;
    else         sdo_oe <= ~pins.cs_n;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) frame_active <= 1'b0;
    else         frame_active <= ~pins.cs_n;
  end

  // ----------------------------------------
  // Power-down
  // ----------------------------------------
  // Sampled only at chip select rise; a later frame end with the pin low wakes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) power_down <= 1'b0;
    else if (cs_rise) power_down <= pins.pd_req;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  oe_follows_cs_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(pins.cs_n) |=> !sdo_oe)
    else $error("output still driven after chip select rose");

  pd_capture_a: assert property (@(posedge clk) disable iff (!arst_n)
    cs_rise |=> power_down == $past(pins.pd_req))
    else $error("power-down not taken at chip select rise");

  pd_stable_a: assert property (@(posedge clk) disable iff (!arst_n)
    !cs_rise |=> $stable(power_down))
    else $error("power-down changed outside chip select rise");

  frame_start_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == DCSR_IDLE && cs_fall) |=> state == DCSR_SHIFT && bit_cnt == BIT_CNT_RST)
    else $error("frame did not start on chip select fall");

  frame_len_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == DCSR_SHIFT && !cs_rise && sclk_rise && bit_cnt == BIT_CNT_W'(FRAME_BITS - 1))
      |=> state == DCSR_DONE)
    else $error("frame did not close after sixteen clocks");

  count_cap_a: assert property (@(posedge clk) disable iff (!arst_n)
    bit_cnt <= BIT_CNT_W'(FRAME_BITS))
    else $error("bit counter beyond frame length");

  sdo_launch_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == DCSR_SHIFT && !sclk_fall && !cs_rise) |=> $stable(sdo_out))
    else $error("output bit changed without serial clock fall");

  msb_first_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == DCSR_SHIFT && sclk_rise && bit_cnt == BIT_CNT_RST && !cs_rise)
      |=> shreg[FRAME_BITS-2] == last_result[RES_W-1])
    else $error("code MSB not first after leading zero");

  chan_route_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == DCSR_IDLE) |=> chan_route == $past(pins.chan_sel))
    else $error("mux select does not follow channel pin");

  // The sample instant must take the channel that the mux was routing
  code_capture_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == DCSR_SHIFT && sclk_rise && bit_cnt == BIT_CNT_RST)
      |=> last_result == ($past(chan_route) ? $past(chan1_code) : $past(chan0_code)))
    else $error("result not taken from the routed channel");

  route_frozen_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == DCSR_SHIFT && bit_cnt != BIT_CNT_RST) |=> $stable(chan_route))
    else $error("mux select moved during conversion");

  hold_in_frame_a: assert property (@(posedge clk) disable iff (!arst_n)
    sample_hold |-> frame_active)
    else $error("sample-hold held outside a frame");
endmodule : dcsr_readout

// >>> dcsr_host.sv
`timescale 1ns/100ps
module dcsr_host (
  output logic      cs_n,  // Chip select, active low
  output logic      sclk,  // Serial clock, low between frames except when stray() toggles it
  output logic      chan,  // Channel select pin
  output logic      pd,    // Power-down request pin
  input  wire logic sdo    // Serial data pin
);
  localparam int HALF = 160;  // 320 ns clock, well below 40 MHz
  // Idle pin levels
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    chan = 1'b0;
    pd   = 1'b0;
  end
  // ----------------------------------------
  // One frame of n clocks under chip select, sixteen when whole
  // ----------------------------------------
  task automatic frame(input logic c, input logic p, input int n, output logic [15:0] word);
    cs_n = 1'b0;
    #HALF chan = c;  // Moved inside the window after the fall
    #HALF;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      word = {word[14:0], sdo};  // Taken on rises, first bit first
      #HALF sclk = 1'b0;
      #HALF;
    end
    pd = p;  // Set up well ahead of the rise
    #HALF cs_n = 1'b1;  // Margin after the conversion
    #(4 * HALF);  // Idle gap keeps the rate far under the limit
  endtask : frame
  // Stray clocks with chip select high
  task automatic stray(input int n);
    repeat (n) begin
      #HALF sclk = 1'b1;
      #HALF sclk = 1'b0;
    end
  endtask : stray
endmodule : dcsr_host

// >>> test_dual_channel_sar_serial_readout.sv
`timescale 1ns/100ps
module test_dual_channel_sar_serial_readout;
  import dcsr_pkg::*;
  typedef struct packed {
    logic c;
    logic p;
    logic [RESULT_BITS-1:0] k0;
    logic [RESULT_BITS-1:0] k1;
  } dcsr_row_t;
  logic                   clk = 1'b0;
  logic                   arst_n = 1'b0;
  logic [RESULT_BITS-1:0] code0 = 14'h0000;
  logic [RESULT_BITS-1:0] code1 = 14'h0000;
  logic [RESULT_BITS-1:0] expc;
  wire                    cs_n, sclk, chan, pd, sdo_pin;
  logic                   sdo_out, sdo_oe, chan_route, sample_hold, power_down, frame_active;
  logic [RESULT_BITS-1:0] last_result;
  logic [15:0]            word;
  int                     bad_count = 0;
  int                     num_checks = 0;
  // Channel and pd alternate so stale state shows up
  dcsr_row_t rows[4] = '{{1'b0, 1'b0, 14'h2AAA, 14'h1555}, {1'b1, 1'b1, 14'h0000, 14'h3FFF},
                         {1'b0, 1'b0, 14'h3FFF, 14'h0000}, {1'b1, 1'b1, 14'h2AAA, 14'h1555}};
  always #20 clk = ~clk;
  // Pin floats when the device lets go
  assign sdo_pin = sdo_oe ? sdo_out : 1'bz;
  dcsr_host host (.cs_n(cs_n), .sclk(sclk), .chan(chan), .pd(pd), .sdo(sdo_pin));
  dcsr_readout dut (
    .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk),
    .input_channel_select(chan), .power_down_request(pd),
    .chan0_code(code0), .chan1_code(code1), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .chan_route(chan_route), .sample_hold(sample_hold), .power_down(power_down),
    .frame_active(frame_active), .last_result(last_result)
  );
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Table of frames, then stray clocks, a cut frame and reset
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    foreach (rows[i]) begin
      repeat (4) @(posedge clk);
      #1 code0 = rows[i].k0;
      code1 = rows[i].k1;
      expc = rows[i].c ? rows[i].k1 : rows[i].k0;
      fork
        host.frame(rows[i].c, rows[i].p, FRAME_BITS, word);
        begin
          #2000;
          check("frame_active", frame_active, 1'b1);
          check("sample_hold", sample_hold, 1'b1);
          check("sdo_oe", sdo_oe, 1'b1);
          check("chan_route", chan_route, rows[i].c);
        end
      join
      check("word", word, {1'b0, expc, 1'b0});
      check("last_result", last_result, expc);
      check("power_down", power_down, rows[i].p);
      check("released", sdo_oe, 1'b0);
      check("frame_end", frame_active, 1'b0);
      check("hold_end", sample_hold, 1'b0);
      $display("frame %0d done", i);
    end
    // Clocks outside a frame must not capture a new code
    @(posedge clk);
    #1 code1 = 14'h0000;
    host.stray(4);
    #400;
    check("idle_result", last_result, rows[3].k1);
    check("idle_oe", sdo_oe, 1'b0);
    check("idle_hold", sample_hold, 1'b0);
    $display("stray clocks done");
    // Frame cut after six clocks: code taken, back to idle, pin still sampled
    @(posedge clk);
    #1 code0 = 14'h2D4B;
    host.frame(1'b0, 1'b1, 6, word);
    check("cut_result", last_result, 14'h2D4B);
    check("cut_word", word[5:0], 6'h16);
    check("cut_oe", sdo_oe, 1'b0);
    check("cut_hold", sample_hold, 1'b0);
    check("cut_pd", power_down, 1'b1);
    $display("cut frame done");
    // Reset in mid-frame clears held state; released with the host idle
    @(posedge clk);
    #1 code0 = 14'h3C3C;
    fork
      host.frame(1'b0, 1'b0, FRAME_BITS, word);
      begin
        #2000;
        check("pre_rst_oe", sdo_oe, 1'b1);
        check("pre_rst_pd", power_down, 1'b1);
        arst_n = 1'b0;
        #40;
        check("rst_pd", power_down, 1'b0);
        check("rst_result", last_result, 14'h0000);
        check("rst_oe", sdo_oe, 1'b0);
        check("rst_active", frame_active, 1'b0);
        check("rst_hold", sample_hold, 1'b0);
      end
    join
    @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 host.frame(1'b0, 1'b0, FRAME_BITS, word);
    check("post_rst_word", word, {1'b0, 14'h3C3C, 1'b0});
    check("post_rst_result", last_result, 14'h3C3C);
    check("post_rst_oe", sdo_oe, 1'b0);
    $display("reset done");
    tally_and_finish();
  end
  // Cut a hang short
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule : test_dual_channel_sar_serial_readout
